// ### src/amc_pkg.sv
package amc_pkg;
  // Datapath widths
  localparam int ACC_W   = 40;
  localparam int DATA_W  = 16;
  localparam int FADDR_W = 13;
  localparam int NUM_W   = 16;
  localparam int INSTR_W = 24;

  // Opcode prefixes and fixed fields
  localparam logic [7:0] OPC_MIN_HI   = 8'hCE;  // Bits 23:16 of both clamp forms
  localparam logic [1:0] OPC_MIN_FIX  = 2'h1;   // Bits 14:13 are 0 then 1
  localparam logic [2:0] OPC_MIN_COND = 3'h4;   // Bits 10:8 mark the conditional form
  localparam logic [8:0] OPC_MOVF     = 9'h17F; // Bits 23:15 of file to destination
  localparam logic [8:0] OPC_MOVWF    = 9'h16F; // Bits 23:15 of default register to file

  // Field positions
  localparam int POS_ACC_SEL = 15;
  localparam int POS_XX_HI   = 12;
  localparam int POS_XX_LO   = 11;
  localparam int POS_FIX7    = 7;
  localparam int POS_Q_HI    = 6;
  localparam int POS_Q_LO    = 4;
  localparam int POS_BYTE    = 14;
  localparam int POS_DEST    = 13;

  // Result format of the clamp
  localparam logic [1:0] XX_MINUS_ONE = 2'h2;
  localparam logic [1:0] XX_EXCESS    = 2'h3;

  // Destination addressing modes
  localparam logic [2:0] AM_DIRECT   = 3'h0;
  localparam logic [2:0] AM_IND      = 3'h1;
  localparam logic [2:0] AM_POST_DEC = 3'h2;
  localparam logic [2:0] AM_POST_INC = 3'h3;
  localparam logic [2:0] AM_PRE_DEC  = 3'h4;
  localparam logic [2:0] AM_PRE_INC  = 3'h5;

  // Constants of the datapath
  localparam logic [15:0] WORD_STEP  = 16'h0002;
  localparam logic [15:0] MINUS_ONE  = 16'hFFFF;
  localparam logic [15:0] SAT_NEG    = 16'h8000;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [3:0]  DEF_WORK_REG = 4'h0;
  localparam logic [40:0] EXCESS_MIN = 41'h1FFFFFF8000;  // -32768 at 41 bits

  // Register port map
  localparam logic [4:0] RA_W_LAST  = 5'h0F;
  localparam logic [4:0] RA_ACC_A_L = 5'h10;
  localparam logic [4:0] RA_ACC_A_M = 5'h11;
  localparam logic [4:0] RA_ACC_A_U = 5'h12;
  localparam logic [4:0] RA_ACC_B_L = 5'h13;
  localparam logic [4:0] RA_ACC_B_M = 5'h14;
  localparam logic [4:0] RA_ACC_B_U = 5'h15;
  localparam logic [4:0] RA_STATUS  = 5'h16;

  // Reset values
  localparam logic [15:0] W_RST   = 16'h0000;
  localparam logic [39:0] ACC_RST = 40'h0000000000;

  typedef struct packed {
    logic acc_b_saturate_bit;
    logic acc_b_overflow_bit;
    logic acc_a_saturate_bit;
    logic acc_a_overflow_bit;
    logic overflow_flag;
    logic n;
    logic z;
  } amc_status_t;

  localparam amc_status_t ST_RST = 7'h00;

  typedef struct packed {
    logic        en;
    logic        byte_op;
    logic [15:0] addr;
    logic [15:0] data;
  } amc_wr_t;

  localparam amc_wr_t WR_IDLE = 34'h000000000;
endpackage : amc_pkg

// ### src/amc_exec.sv
`timescale 1ns/1ps
module amc_exec
  import amc_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_instr_valid,
  input  wire logic [23:0]       i_instr,
  output logic      [12:0]       o_fr_addr,
  output logic                   o_fr_rd,
  input  wire logic [15:0]       i_fr_rdata,
  output amc_wr_t                o_mem_wr,
  input  wire logic [4:0]        i_reg_addr,
  input  wire logic [15:0]       i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [15:0]       o_reg_rdata,
  output amc_status_t            o_status
);

  logic [15:0]  w_r [NUM_W];
  logic [39:0]  acc_r [2];
  amc_status_t  st_r;
  amc_status_t  st_nxt;
  amc_wr_t      mem_wr_nxt;

  logic         is_min;
  logic         is_movf;
  logic         is_movwf;
  logic         min_exec;
  logic         acc_sel;
  logic [1:0]   fmt;
  logic [2:0]   amode;
  logic [3:0]   dreg;
  logic         byte_op;
  logic         dest_file;
  logic [12:0]  faddr;
  logic [40:0]  diff;
  logic         less;
  logic         sat;
  logic [15:0]  dest_val;
  logic         w_we;
  logic [3:0]   w_idx;
  logic [15:0]  w_val;
  logic         acc_we;
  logic [15:0]  moved;

  // Sign extend a 40-bit accumulator for a borrow-free compare
  function automatic logic [40:0] sext41(input logic [39:0] v);
    return {v[39], v};
  endfunction : sext41

  // Negative and zero of a moved value, word or byte wide
  function automatic logic [1:0] nz_of(input logic [15:0] v, input logic b);
    return b ? {v[7], (v[7:0] == 8'h00)} : {v[15], (v == WORD_ZERO)};
  endfunction : nz_of

  assign is_min   = i_instr_valid && (i_instr[23:16] == OPC_MIN_HI) && !i_instr[POS_FIX7]
                  && (i_instr[14:13] == OPC_MIN_FIX) && (i_instr[10:8] == OPC_MIN_COND);
  assign acc_sel  = i_instr[POS_ACC_SEL];
  assign fmt      = i_instr[POS_XX_HI:POS_XX_LO];
  assign amode    = i_instr[POS_Q_HI:POS_Q_LO];
  assign dreg     = i_instr[3:0];
  assign is_movf  = i_instr_valid && (i_instr[23:15] == OPC_MOVF);
  assign is_movwf = i_instr_valid && (i_instr[23:15] == OPC_MOVWF) && i_instr[POS_DEST];
  assign byte_op  = i_instr[POS_BYTE];
  assign dest_file = i_instr[POS_DEST];
  assign faddr    = i_instr[12:0];

  assign min_exec = is_min && st_r.z;

  // Full-width compare of target against the other accumulator
  assign diff = sext41(acc_r[acc_sel]) - sext41(acc_r[!acc_sel]);
  assign less = diff[40];
  // Excess below the signed 16-bit range
  assign sat  = less && ($signed(diff) < $signed(EXCESS_MIN));

  // Clamp result for the destination register
  always_comb begin
    dest_val = WORD_ZERO;
    if (less) begin
      if (fmt == XX_MINUS_ONE) begin
        dest_val = MINUS_ONE;
      end else if (fmt == XX_EXCESS) begin
        dest_val = sat ? SAT_NEG : diff[15:0];
      end
    end
  end

  // Read side of the file port is combinational so the move finishes in one cycle
  assign o_fr_addr = faddr;
  assign o_fr_rd   = is_movf;
  assign moved     = byte_op ? {8'h00, i_fr_rdata[7:0]} : i_fr_rdata;

  // Working register write, memory write and flag update of the issued instruction
  always_comb begin
    w_we       = 1'b0;
    w_idx      = dreg;
    w_val      = dest_val;
    mem_wr_nxt = WR_IDLE;
    st_nxt     = st_r;
    acc_we     = 1'b0;
    if (min_exec) begin
      st_nxt.overflow_flag = 1'b0;
      st_nxt.z  = !less;
      st_nxt.n  = less;
      acc_we    = less;
      if (fmt[1]) begin
        unique case (amode)
          AM_DIRECT: begin
            w_we = 1'b1;
          end
          AM_IND: begin
            mem_wr_nxt = '{en: 1'b1, byte_op: 1'b0, addr: w_r[dreg], data: dest_val};
          end
          AM_POST_DEC, AM_POST_INC: begin
            mem_wr_nxt = '{en: 1'b1, byte_op: 1'b0, addr: w_r[dreg], data: dest_val};
            w_we  = 1'b1;
            w_val = amode[0] ? (w_r[dreg] + WORD_STEP) : (w_r[dreg] - WORD_STEP);
          end
          AM_PRE_DEC, AM_PRE_INC: begin
            w_we  = 1'b1;
            w_val = amode[0] ? (w_r[dreg] + WORD_STEP) : (w_r[dreg] - WORD_STEP);
            mem_wr_nxt = '{en: 1'b1, byte_op: 1'b0, addr: w_val, data: dest_val};
          end
          default: begin
            w_we = 1'b0;  // Reserved modes write no destination; the accumulator and flags still update
          end
        endcase
      end
    end else if (is_movf) begin
      {st_nxt.n, st_nxt.z} = nz_of(moved, byte_op);
      if (!dest_file) begin
        w_we  = 1'b1;
        w_idx = DEF_WORK_REG;
        // Byte move keeps the upper byte
        w_val = byte_op ? {w_r[DEF_WORK_REG][15:8], i_fr_rdata[7:0]} : i_fr_rdata;
      end
    end else if (is_movwf) begin
      mem_wr_nxt = '{en: 1'b1, byte_op: byte_op, addr: {3'h0, faddr},
                     data: byte_op ? {8'h00, w_r[DEF_WORK_REG][7:0]} : w_r[DEF_WORK_REG]};
    end
  end

  // Working registers commit at the issuing edge; instruction beats the port
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_W; i++) begin
        w_r[i] <= W_RST;
      end
    end else begin
      if (i_reg_wr && (i_reg_addr <= RA_W_LAST)) begin
        w_r[i_reg_addr[3:0]] <= i_reg_wdata;
      end
      if (w_we) begin
        w_r[w_idx] <= w_val;
      end
    end
  end

  // Clamp loads the limit into the target
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_r[0] <= ACC_RST;
      acc_r[1] <= ACC_RST;
    end else begin
      if (i_reg_wr) begin
        unique case (i_reg_addr)
          RA_ACC_A_L: acc_r[0][15:0]  <= i_reg_wdata;
          RA_ACC_A_M: acc_r[0][31:16] <= i_reg_wdata;
          RA_ACC_A_U: acc_r[0][39:32] <= i_reg_wdata[7:0];
          RA_ACC_B_L: acc_r[1][15:0]  <= i_reg_wdata;
          RA_ACC_B_M: acc_r[1][31:16] <= i_reg_wdata;
          RA_ACC_B_U: acc_r[1][39:32] <= i_reg_wdata[7:0];
          default:   ;
        endcase
      end
      if (acc_we) begin
        acc_r[acc_sel] <= acc_r[!acc_sel];
      end
    end
  end

  // Status: port writes all bits, only the DSP bits in an executed clamp or file move cycle; instructions never touch the DSP bits
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= ST_RST;
    end else if (min_exec || is_movf) begin
      st_r    <= st_nxt;
      if (i_reg_wr && (i_reg_addr == RA_STATUS)) begin
        st_r.acc_a_overflow_bit <= i_reg_wdata[3];
        st_r.acc_a_saturate_bit <= i_reg_wdata[4];
        st_r.acc_b_overflow_bit <= i_reg_wdata[5];
        st_r.acc_b_saturate_bit <= i_reg_wdata[6];
      end
    end else if (i_reg_wr && (i_reg_addr == RA_STATUS)) begin
      st_r <= i_reg_wdata[6:0];
    end
  end

  // Memory write leaves on a flop, one cycle after issue
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mem_wr <= WR_IDLE;
    end else begin
      o_mem_wr <= mem_wr_nxt;
    end
  end

  // Register port read data, valid only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= WORD_ZERO;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        RA_ACC_A_L: o_reg_rdata <= acc_r[0][15:0];
        RA_ACC_A_M: o_reg_rdata <= acc_r[0][31:16];
        RA_ACC_A_U: o_reg_rdata <= {8'h00, acc_r[0][39:32]};
        RA_ACC_B_L: o_reg_rdata <= acc_r[1][15:0];
        RA_ACC_B_M: o_reg_rdata <= acc_r[1][31:16];
        RA_ACC_B_U: o_reg_rdata <= {8'h00, acc_r[1][39:32]};
        RA_STATUS: o_reg_rdata <= {9'h000, st_r};
        default:   o_reg_rdata <= (i_reg_addr <= RA_W_LAST) ? w_r[i_reg_addr[3:0]] : WORD_ZERO;
      endcase
    end else begin
      o_reg_rdata <= WORD_ZERO;
    end
  end

  assign o_status = st_r;

  // Checks below watch the core's own state
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_clamp_quiet;
    min_exec && !i_reg_wr;
  endsequence

  sequence s_clamp_hit;
    s_clamp_quiet ##0 less;
  endsequence

  sequence s_clamp_pass;
    s_clamp_quiet ##0 !less;
  endsequence

  AST_SKIP_NOP: assert property (is_min && !st_r.z && !i_reg_wr |=>
    $stable(acc_r[0]) && $stable(acc_r[1]) && $stable(st_r) && !o_mem_wr.en
    && w_r[$past(dreg)] == $past(w_r[dreg]))
    else $error("Skipped clamp changed state");

  AST_CLAMP_LOAD: assert property (s_clamp_hit |=>
    acc_r[$past(acc_sel)] == $past(acc_r[!acc_sel]) && !st_r.z && st_r.n)
    else $error("Clamp did not load the limit or set flags");

  AST_PASS_KEEP: assert property (s_clamp_pass |=>
    acc_r[$past(acc_sel)] == $past(acc_r[acc_sel]) && st_r.z && !st_r.n)
    else $error("Passing clamp changed target or flags");

  AST_OV_CLEAR: assert property (s_clamp_quiet |=> !st_r.overflow_flag)
    else $error("Overflow flag not cleared by clamp");

  AST_DSP_BITS: assert property (s_clamp_quiet |=>
    $stable({st_r.acc_b_saturate_bit, st_r.acc_b_overflow_bit})
    && $stable({st_r.acc_a_saturate_bit, st_r.acc_a_overflow_bit}))
    else $error("Clamp altered accumulator status bits");

  AST_EXCESS_SAT: assert property (s_clamp_hit ##0 (fmt == XX_EXCESS) ##0 (amode == AM_DIRECT)
    |=> w_r[$past(dreg)] == (($signed($past(diff)) < -32768) ? SAT_NEG : $past(diff[15:0])))
    else $error("Excess result wrong");

  AST_MINUS_ONE: assert property (s_clamp_hit ##0 (fmt == XX_MINUS_ONE) ##0 (amode == AM_DIRECT)
    |=> w_r[$past(dreg)] == MINUS_ONE)
    else $error("Minus one result wrong");

  AST_ZERO_WRITE: assert property (s_clamp_pass ##0 fmt[1] ##0 (amode == AM_DIRECT)
    |=> w_r[$past(dreg)] == WORD_ZERO)
    else $error("Passing clamp did not clear destination");

  AST_POST_INC: assert property (s_clamp_quiet ##0 fmt[1] ##0 (amode == AM_POST_INC)
    |=> o_mem_wr.en && o_mem_wr.addr == $past(w_r[dreg]) && w_r[$past(dreg)] == o_mem_wr.addr + WORD_STEP)
    else $error("Post-increment destination wrong");

  sequence s_movf_quiet;
    is_movf && !i_reg_wr;
  endsequence

  AST_MOVF_FLAGS: assert property (s_movf_quiet |=>
    st_r.n == ($past(byte_op) ? $past(i_fr_rdata[7]) : $past(i_fr_rdata[15]))
    && st_r.z == ($past(byte_op) ? ($past(i_fr_rdata[7:0]) == 8'h00) : ($past(i_fr_rdata) == WORD_ZERO))
    && st_r.overflow_flag == $past(st_r.overflow_flag))
    else $error("File move flags wrong");

  AST_MOVF_BYTE: assert property (s_movf_quiet ##0 (!dest_file && byte_op) |=>
    w_r[DEF_WORK_REG] == {$past(w_r[DEF_WORK_REG][15:8]), $past(i_fr_rdata[7:0])})
    else $error("Byte move disturbed the upper byte");

  AST_MOVF_WORD: assert property (s_movf_quiet ##0 (!dest_file && !byte_op) |=>
    w_r[DEF_WORK_REG] == $past(i_fr_rdata))
    else $error("Word move did not reach register zero");

  AST_MOVF_BACK: assert property (s_movf_quiet ##0 dest_file |=>
    $stable(w_r[DEF_WORK_REG]) && !o_mem_wr.en)
    else $error("Move back to file changed a register");

  AST_MOVWF_STORE: assert property (is_movwf && !i_reg_wr |=>
    o_mem_wr.en && o_mem_wr.addr == {3'h0, $past(faddr)} && $stable(st_r))
    else $error("Store move wrong");

  AST_MOVWF_DATA: assert property (is_movwf && !i_reg_wr |=>
    o_mem_wr.byte_op == $past(byte_op) && o_mem_wr.data[7:0] == $past(w_r[DEF_WORK_REG][7:0]))
    else $error("Store move data or width wrong");
endmodule : amc_exec

// ### verification/amc_exec_tb_top.sv
`timescale 1ns/1ps
module amc_exec_tb_top
  import amc_pkg::*;
;
  logic        sys_clk;
  logic        sys_rst;
  logic        instr_valid;
  logic [23:0] instr;
  logic [12:0] fr_addr;
  logic        fr_rd;
  logic [15:0] fr_rdata;
  amc_wr_t     mem_wr;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  amc_status_t status;
  int          num_errors;
  int          total_checks;
  amc_wr_t     wr_seen;
  logic        rd_seen;
  logic [12:0] addr_seen;
  logic [15:0] rv;

  // Expected memory address and final pointer for each destination mode
  localparam logic [15:0] IND_A [6] = '{16'h0000, 16'h0900, 16'h0900, 16'h0900, 16'h08FE, 16'h0902};
  localparam logic [15:0] FIN_W [6] = '{16'h0000, 16'h0900, 16'h08FE, 16'h0902, 16'h08FE, 16'h0902};

  // Free-running core clock, 100 ns period
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  amc_exec dut (
    .i_sys_clk     (sys_clk),
    .i_sys_rst     (sys_rst),
    .i_instr_valid (instr_valid),
    .i_instr       (instr),
    .o_fr_addr     (fr_addr),
    .o_fr_rd       (fr_rd),
    .i_fr_rdata    (fr_rdata),
    .o_mem_wr      (mem_wr),
    .i_reg_addr    (reg_addr),
    .i_reg_wdata   (reg_wdata),
    .i_reg_wr      (reg_wr),
    .i_reg_rd      (reg_rd),
    .o_reg_rdata   (reg_rdata),
    .o_status      (status)
  );

  // Verdict and end of run
  task automatic report_and_stop;
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // Word results
  task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk16

  // Status flags
  task automatic chk_st(input amc_status_t exp, input amc_status_t got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch status expected %h seen %h", exp, got);
    end
  endtask : chk_st

  // Memory write; idle fields and the unused byte lane are not compared
  task automatic chk_wr(input amc_wr_t exp, input amc_wr_t got);
    total_checks++;
    if (exp.en === 1'b0) got = {got.en, exp[32:0]};
    else if (exp.byte_op === 1'b1) got.data[15:8] = exp.data[15:8];
    if (got !== exp) begin
      num_errors++;
      $display("mismatch mem_wr expected %h seen %h", exp, got);
    end
  endtask : chk_wr

  // Register port write: one-cycle strobe
  task automatic reg_w(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_w

  // Register port read: data stands only in the cycle after the strobe
  task automatic reg_r(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : reg_r

  // Accumulators travel as low, middle and upper words
  task automatic acc_w(input logic [4:0] base, input logic [39:0] v);
    reg_w(base, v[15:0]);
    reg_w(base + 5'h01, v[31:16]);
    reg_w(base + 5'h02, {8'h00, v[39:32]});
  endtask : acc_w

  task automatic acc_chk(input logic [4:0] base, input logic [39:0] v);
    logic [15:0] d;
    reg_r(base, d);
    chk16("acc_l", v[15:0], d);
    reg_r(base + 5'h01, d);
    chk16("acc_m", v[31:16], d);
    reg_r(base + 5'h02, d);
    chk16("acc_u", {8'h00, v[39:32]}, d);
  endtask : acc_chk

  // One instruction; file read strobe seen in issue cycle, memory write one cycle later
  task automatic run(input logic [23:0] w, input logic [15:0] frd);
    @(posedge sys_clk);
    instr       <= w;
    fr_rdata    <= frd;
    instr_valid <= 1'b1;
    @(negedge sys_clk);
    rd_seen   = fr_rd;
    addr_seen = fr_addr;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    @(negedge sys_clk);
    wr_seen = mem_wr;
  endtask : run

  function automatic logic [23:0] mk_min(input logic a, input logic [1:0] xx, input logic [2:0] q, input logic [3:0] d);
    return {OPC_MIN_HI, a, OPC_MIN_FIX, xx, OPC_MIN_COND, 1'b0, q, d};
  endfunction : mk_min

  // Main sequence
  initial begin
    sys_rst      = 1'b1;
    instr_valid  = 1'b0;
    instr        = 24'h000000;
    fr_rdata     = 16'h0000;
    reg_addr     = 5'h00;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    num_errors   = 0;
    total_checks = 0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset contents and an unmapped address
    reg_r(5'h03, rv);
    chk16("w3", W_RST, rv);
    acc_chk(RA_ACC_A_L, ACC_RST);
    reg_w(5'h17, 16'hBEEF);
    reg_r(5'h17, rv);
    chk16("unmapped", 16'h0000, rv);
    // Zero flag clear: clamp must be skipped although a clamp is due
    reg_w(5'h03, 16'h1234);
    acc_w(RA_ACC_A_L, 40'h0000000005);
    acc_w(RA_ACC_B_L, 40'h000000000A);
    reg_w(RA_STATUS, 16'h0004);
    run(mk_min(1'b0, XX_MINUS_ONE, AM_DIRECT, 4'h3), 16'h0000);
    reg_r(5'h03, rv);
    chk16("w3", 16'h1234, rv);
    acc_chk(RA_ACC_A_L, 40'h0000000005);
    chk_st(7'h04, status);
    // Below the limit only when all 40 bits count; DSP bits must survive
    acc_w(RA_ACC_A_L, 40'h8000000005);
    acc_w(RA_ACC_B_L, 40'h0000000003);
    reg_w(RA_STATUS, 16'h004D);
    run(mk_min(1'b0, XX_MINUS_ONE, AM_DIRECT, 4'h3), 16'h0000);
    chk_st(7'h4A, status);
    chk_wr(WR_IDLE, wr_seen);
    acc_chk(RA_ACC_A_L, 40'h0000000003);
    reg_r(5'h03, rv);
    chk16("w3", MINUS_ONE, rv);
    // Second accumulator as target, excess value reported
    acc_w(RA_ACC_A_L, 40'h0000000030);
    acc_w(RA_ACC_B_L, 40'h0000000010);
    // Zero flag set as a passing maximum clamp just before would leave it
    reg_w(RA_STATUS, 16'h0001);
    run(mk_min(1'b1, XX_EXCESS, AM_DIRECT, 4'h5), 16'h0000);
    acc_chk(RA_ACC_B_L, 40'h0000000030);
    reg_r(5'h05, rv);
    chk16("w5", 16'hFFE0, rv);
    chk_st(7'h02, status);
    // Excess one past the signed range, written through a pointer
    acc_w(RA_ACC_A_L, 40'h0000000000);
    acc_w(RA_ACC_B_L, 40'h0000008001);
    reg_w(5'h04, 16'h0800);
    reg_w(RA_STATUS, 16'h0001);
    run(mk_min(1'b0, XX_EXCESS, AM_IND, 4'h4), 16'h0000);
    chk_wr({1'b1, 1'b0, 16'h0800, SAT_NEG}, wr_seen);
    // Equal accumulators: no clamp, zero stored through every mode
    acc_w(RA_ACC_A_L, 40'h0000000100);
    acc_w(RA_ACC_B_L, 40'h0000000100);
    reg_w(RA_STATUS, 16'h0001);
    for (int m = 0; m < 6; m++) begin
      reg_w(5'h06, 16'h0900);
      run(mk_min(1'b0, XX_EXCESS, m[2:0], 4'h6), 16'h0000);
      chk_wr({m != 0, 1'b0, IND_A[m], WORD_ZERO}, wr_seen);
      reg_r(5'h06, rv);
      chk16("w6", FIN_W[m], rv);
      chk_st(7'h01, status);
    end
    acc_chk(RA_ACC_A_L, 40'h0000000100);
    // Byte move into the default register keeps its upper byte
    reg_w(5'h00, 16'h9080);
    reg_w(RA_STATUS, 16'h000C);
    run({OPC_MOVF, 1'b1, 1'b0, 13'h1ABC}, 16'h2355);
    chk16("fr_addr", 16'h1ABC, {3'h0, addr_seen});
    chk16("fr_rd", 16'h0001, {15'h0000, rd_seen});
    reg_r(5'h00, rv);
    chk16("w0", 16'h9055, rv);
    chk_st(7'h0C, status);
    // Word move back to the file only sets flags
    run({OPC_MOVF, 1'b0, 1'b1, 13'h1FFF}, 16'hB29F);
    reg_r(5'h00, rv);
    chk16("w0", 16'h9055, rv);
    chk_st(7'h0E, status);
    chk_wr(WR_IDLE, wr_seen);
    // Word move into the default register takes the whole word
    run({OPC_MOVF, 1'b0, 1'b0, 13'h0002}, 16'h0100);
    reg_r(5'h00, rv);
    chk16("w0", 16'h0100, rv);
    chk_st(7'h0C, status);
    // Byte flags ignore a set upper byte
    run({OPC_MOVF, 1'b1, 1'b1, 13'h0800}, 16'hFF00);
    chk_st(7'h0D, status);
    // Default register stored to file, byte and word, flags untouched
    reg_w(5'h00, 16'h98F3);
    run({OPC_MOVWF, 1'b1, 1'b1, 13'h0801}, 16'h0000);
    chk_wr({1'b1, 1'b1, 16'h0801, 16'h00F3}, wr_seen);
    chk_st(7'h0D, status);
    run({OPC_MOVWF, 1'b0, 1'b1, 13'h1FFE}, 16'h0000);
    chk_wr({1'b1, 1'b0, 16'h1FFE, 16'h98F3}, wr_seen);
    // Store form with its fixed bit clear is not decoded
    run({OPC_MOVWF, 1'b0, 1'b0, 13'h0100}, 16'h0000);
    chk_wr(WR_IDLE, wr_seen);
    report_and_stop();
  end

  // Hang guard: the whole sequence is far shorter than this
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end
endmodule : amc_exec_tb_top
